// >>> rtl/tlio_pkg.sv
package tlio_pkg;

	// ****************************************
	// Object indices and subindices
	// ****************************************
	localparam logic [15:0] IDX_MAX_TORQUE   = 16'h6072;
	localparam logic [15:0] IDX_POS_LIMIT    = 16'h60E0;
	localparam logic [15:0] IDX_NEG_LIMIT    = 16'h60E1;
	localparam logic [15:0] IDX_INPUT_WORD   = 16'h60FD;
	localparam logic [15:0] IDX_OUTPUT_OBJ   = 16'h60FE;
	localparam logic [7:0]  SUB_ENTRY_COUNT  = 8'h00;
	localparam logic [7:0]  SUB_OUT_STATE    = 8'h01;
	localparam logic [7:0]  SUB_OUT_MASK     = 8'h02;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] MAX_TORQUE_RESET = 16'h0BB8;
	localparam logic [15:0] LIMIT_RESET      = 16'hFFFF;
	localparam logic [31:0] OUT_WORD_RESET   = 32'h0000_0000;
	localparam logic [7:0]  OUT_ENTRY_COUNT  = 8'h02;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int          IN_NEG_OT_BIT    = 0;
	localparam int          IN_POS_OT_BIT    = 1;
	localparam int          IN_HOME_BIT      = 2;
	localparam int          IN_CONN_LSB      = 16;
	localparam int          CONN_INPUTS      = 5;
	localparam int          GP_OUT_LSB       = 16;
	localparam int          GP_OUTPUTS       = 4;
	localparam int          REMOTE_OUT_LSB   = 24;
	localparam int          REMOTE_OUTPUTS   = 4;
	localparam int          SEL_W            = 2;
	localparam logic [31:0] OUT_WRITABLE     = 32'h0F0F_0000;
	localparam logic        LEVEL_INACTIVE   = 1'b1;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [15:0] index;
		logic [7:0]  subindex;
		logic        write;
		logic        read;
		logic [31:0] wdata;
	} tlio_obj_req_type;

	typedef struct packed {
		logic [15:0] pos;
		logic [15:0] neg;
	} tlio_limit_type;

endpackage : tlio_pkg

// >>> rtl/tlio_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tlio_sync #(
	parameter int         WIDTH      = 1,
	parameter logic [0:0] REST_LEVEL = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] raw,
	output var  logic [WIDTH-1:0] clean
);

	// ****************************************
	// Three stages, accept once stages two and three agree
	// ****************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1;
		logic s2;
		logic s3;
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				s1 <= REST_LEVEL;
				s2 <= REST_LEVEL;
				s3 <= REST_LEVEL;
				clean[i] <= REST_LEVEL;
			end else if (ce) begin
				s1 <= raw[i];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					clean[i] <= s3;
				end
			end
		end
	end

endmodule : tlio_sync

`default_nettype wire

// >>> rtl/tlio_top.sv
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Output torque never exceeds maximum torque setting
// - Positive limit is min of max and positive
// - Negative limit is min of max and negative
// - Bits 0-2 show overtravel and home switches
// - Bits 16-20 show connector inputs, 0 active
// - Remote-marked inputs not used internally
// - Output object holds states plus enable mask
// - Bits 16-19 drive general outputs when masked
// - Route general outputs and apply polarity inversion
// - Bits 24-27 drive allocated remote outputs
// - Output word zero means active output
module tlio_top #(
	parameter int TORQUE_W = 16
) (
	input  wire logic                                            CLK_SYS,
	input  wire logic                                            SYS_RST,
	input  wire logic                                            CLK_EN,
	input  wire tlio_pkg::tlio_obj_req_type                      OBJ_REQ,
	output var  logic [31:0]                                     OBJ_RDATA,
	output var  logic                                            OBJ_ACK,
	output var  logic                                            OBJ_ERR,
	input  wire logic signed [TORQUE_W-1:0]                      TORQUE_REF,
	output var  logic signed [TORQUE_W-1:0]                      TORQUE_OUT,
	output var  tlio_pkg::tlio_limit_type                        TORQUE_LIMIT,
	input  wire logic                                            NEG_OVERTRAVEL_SWITCH,
	input  wire logic                                            POSITIVE_OVERTRAVEL_SWITCH,
	input  wire logic                                            HOME_SWITCH,
	input  wire logic [tlio_pkg::CONN_INPUTS-1:0]                IO_CONNECTOR_IN_N,
	input  wire logic [tlio_pkg::CONN_INPUTS-1:0]                INPUT_ALLOCATION_SETTING_A,
	input  wire logic [tlio_pkg::CONN_INPUTS-1:0]                INPUT_ALLOCATION_SETTING_B,
	output var  logic [tlio_pkg::CONN_INPUTS-1:0]                CONN_INTERNAL_N,
	input  wire logic [tlio_pkg::GP_OUTPUTS*tlio_pkg::SEL_W-1:0] GP_OUTPUT_ROUTE,
	input  wire logic [tlio_pkg::GP_OUTPUTS-1:0]                 BUS_OUTPUT_ENABLE_A,
	input  wire logic [tlio_pkg::GP_OUTPUTS-1:0]                 BUS_OUTPUT_ENABLE_B,
	input  wire logic [tlio_pkg::GP_OUTPUTS-1:0]                 OUTPUT_POLARITY_SETTING_A,
	input  wire logic [tlio_pkg::GP_OUTPUTS-1:0]                 OUTPUT_POLARITY_SETTING_B,
	output var  logic [tlio_pkg::GP_OUTPUTS-1:0]                 IO_CONNECTOR_OUT_N,
	input  wire logic [tlio_pkg::REMOTE_OUTPUTS*tlio_pkg::SEL_W-1:0] REMOTE_OUTPUT_ALLOCATION,
	output var  logic [tlio_pkg::REMOTE_OUTPUTS-1:0]             REMOTE_OUT_N
);

	// ****************************************
	// Object storage
	// ****************************************
	logic [15:0] max_torque_setting;
	logic [15:0] positive_torque_limit;
	logic [15:0] negative_torque_limit;
	logic [31:0] output_state_word;
	logic [31:0] output_enable_mask;
	logic [31:0] input_state_word;

	logic is_max;
	logic is_pos;
	logic is_neg;
	logic is_in;
	logic is_cnt;
	logic is_st;
	logic is_msk;
	logic access;

	assign access = OBJ_REQ.write | OBJ_REQ.read;
	assign is_max = OBJ_REQ.index == tlio_pkg::IDX_MAX_TORQUE
		&& OBJ_REQ.subindex == tlio_pkg::SUB_ENTRY_COUNT;
	assign is_pos = OBJ_REQ.index == tlio_pkg::IDX_POS_LIMIT
		&& OBJ_REQ.subindex == tlio_pkg::SUB_ENTRY_COUNT;
	assign is_neg = OBJ_REQ.index == tlio_pkg::IDX_NEG_LIMIT
		&& OBJ_REQ.subindex == tlio_pkg::SUB_ENTRY_COUNT;
	assign is_in  = OBJ_REQ.index == tlio_pkg::IDX_INPUT_WORD
		&& OBJ_REQ.subindex == tlio_pkg::SUB_ENTRY_COUNT;
	assign is_cnt = OBJ_REQ.index == tlio_pkg::IDX_OUTPUT_OBJ
		&& OBJ_REQ.subindex == tlio_pkg::SUB_ENTRY_COUNT;
	assign is_st  = OBJ_REQ.index == tlio_pkg::IDX_OUTPUT_OBJ
		&& OBJ_REQ.subindex == tlio_pkg::SUB_OUT_STATE;
	assign is_msk = OBJ_REQ.index == tlio_pkg::IDX_OUTPUT_OBJ
		&& OBJ_REQ.subindex == tlio_pkg::SUB_OUT_MASK;

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			max_torque_setting <= tlio_pkg::MAX_TORQUE_RESET;
			positive_torque_limit <= tlio_pkg::LIMIT_RESET;
			negative_torque_limit <= tlio_pkg::LIMIT_RESET;
		end else if (CLK_EN && OBJ_REQ.write) begin
			if (is_max) begin
				max_torque_setting <= OBJ_REQ.wdata[15:0];
			end
			if (is_pos) begin
				positive_torque_limit <= OBJ_REQ.wdata[15:0];
			end
			if (is_neg) begin
				negative_torque_limit <= OBJ_REQ.wdata[15:0];
			end
		end
	end

	// Only the mapped output bits are kept, so reserved ones stay zero
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			output_state_word <= tlio_pkg::OUT_WORD_RESET;
			output_enable_mask <= tlio_pkg::OUT_WORD_RESET;
		end else if (CLK_EN && OBJ_REQ.write) begin
			if (is_st) begin
				output_state_word <= OBJ_REQ.wdata & tlio_pkg::OUT_WRITABLE;
			end
			if (is_msk) begin
				output_enable_mask <= OBJ_REQ.wdata & tlio_pkg::OUT_WRITABLE;
			end
		end
	end

	// ****************************************
	// Object answer
	// ****************************************
	logic [31:0] next_rdata;
	logic        next_err;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (is_max) begin
			next_rdata[15:0] = max_torque_setting;
		end else if (is_pos) begin
			next_rdata[15:0] = positive_torque_limit;
		end else if (is_neg) begin
			next_rdata[15:0] = negative_torque_limit;
		end else if (is_in) begin
			next_rdata = input_state_word;
			next_err = OBJ_REQ.write;
		end else if (is_cnt) begin
			next_rdata[7:0] = tlio_pkg::OUT_ENTRY_COUNT;
			next_err = OBJ_REQ.write;
		end else if (is_st) begin
			next_rdata = output_state_word;
		end else if (is_msk) begin
			next_rdata = output_enable_mask;
		end else begin
			next_err = 1'b1;
		end
		if (!OBJ_REQ.read) begin
			next_rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			OBJ_RDATA <= 32'h0000_0000;
			OBJ_ACK <= 1'b0;
			OBJ_ERR <= 1'b0;
		end else if (CLK_EN) begin
			OBJ_RDATA <= next_rdata;
			OBJ_ACK <= access;
			OBJ_ERR <= access & next_err;
		end
	end

	// ****************************************
	// Torque clamp
	// ****************************************
	logic [15:0] eff_pos;
	logic [15:0] eff_neg;
	logic signed [TORQUE_W+1:0] ref_wide;
	logic signed [TORQUE_W+1:0] pos_wide;
	logic signed [TORQUE_W+1:0] neg_wide;
	logic signed [TORQUE_W+1:0] clamped;

	assign eff_pos = (max_torque_setting < positive_torque_limit)
		? max_torque_setting : positive_torque_limit;
	assign eff_neg = (max_torque_setting < negative_torque_limit)
		? max_torque_setting : negative_torque_limit;
	assign ref_wide = (TORQUE_W+2)'(TORQUE_REF);
	assign pos_wide = (TORQUE_W+2)'($signed({2'b00, eff_pos}));
	assign neg_wide = -(TORQUE_W+2)'($signed({2'b00, eff_neg}));

	// Limits above the reference range simply never bind
	always_comb begin
		clamped = ref_wide;
		if (ref_wide > pos_wide) begin
			clamped = pos_wide;
		end else if (ref_wide < neg_wide) begin
			clamped = neg_wide;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			TORQUE_OUT <= '0;
			TORQUE_LIMIT <= '0;
		end else if (CLK_EN) begin
			TORQUE_OUT <= clamped[TORQUE_W-1:0];
			TORQUE_LIMIT.pos <= eff_pos;
			TORQUE_LIMIT.neg <= eff_neg;
		end
	end

	// ****************************************
	// Inputs
	// ****************************************
	logic [2:0]                       sw_clean;
	logic [tlio_pkg::CONN_INPUTS-1:0] conn_clean;
	logic [tlio_pkg::CONN_INPUTS-1:0] conn_remote;

	tlio_sync #(.WIDTH(3), .REST_LEVEL(1'b0)) u_sw_sync (
		.clk   (CLK_SYS),
		.rst   (SYS_RST),
		.ce    (CLK_EN),
		.raw   ({HOME_SWITCH, POSITIVE_OVERTRAVEL_SWITCH, NEG_OVERTRAVEL_SWITCH}),
		.clean (sw_clean)
	);

	tlio_sync #(.WIDTH(tlio_pkg::CONN_INPUTS), .REST_LEVEL(tlio_pkg::LEVEL_INACTIVE)) u_conn_sync (
		.clk   (CLK_SYS),
		.rst   (SYS_RST),
		.ce    (CLK_EN),
		.raw   (IO_CONNECTOR_IN_N),
		.clean (conn_clean)
	);

	assign conn_remote = INPUT_ALLOCATION_SETTING_A | INPUT_ALLOCATION_SETTING_B;

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			input_state_word <= 32'h0000_0000;
		end else if (CLK_EN) begin
			input_state_word <= 32'h0000_0000;
			input_state_word[tlio_pkg::IN_NEG_OT_BIT] <= sw_clean[0];
			input_state_word[tlio_pkg::IN_POS_OT_BIT] <= sw_clean[1];
			input_state_word[tlio_pkg::IN_HOME_BIT] <= sw_clean[2];
			input_state_word[tlio_pkg::IN_CONN_LSB +: tlio_pkg::CONN_INPUTS] <= conn_clean;
		end
	end

	// Remote inputs read back on the bus but look inactive to the drive
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			CONN_INTERNAL_N <= {tlio_pkg::CONN_INPUTS{tlio_pkg::LEVEL_INACTIVE}};
		end else if (CLK_EN) begin
			CONN_INTERNAL_N <= conn_clean | conn_remote;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic [31:0] eff_word;

	// Unmasked bits fall back to inactive level
	assign eff_word = (output_state_word & output_enable_mask)
		| ~output_enable_mask;

	for (genvar k = 0; k < tlio_pkg::GP_OUTPUTS; k++) begin : g_gp
		logic [tlio_pkg::SEL_W-1:0] sel;
		logic                       bus_on;
		logic                       lvl;
		assign sel = GP_OUTPUT_ROUTE[k*tlio_pkg::SEL_W +: tlio_pkg::SEL_W];
		assign bus_on = BUS_OUTPUT_ENABLE_A[k] | BUS_OUTPUT_ENABLE_B[k];
		assign lvl = bus_on ? eff_word[tlio_pkg::GP_OUT_LSB + int'(sel)]
			: tlio_pkg::LEVEL_INACTIVE;
		always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
			if (SYS_RST) begin
				IO_CONNECTOR_OUT_N[k] <= tlio_pkg::LEVEL_INACTIVE;
			end else if (CLK_EN) begin
				IO_CONNECTOR_OUT_N[k] <= lvl
					^ (OUTPUT_POLARITY_SETTING_A[k] ^ OUTPUT_POLARITY_SETTING_B[k]);
			end
		end
	end

	for (genvar r = 0; r < tlio_pkg::REMOTE_OUTPUTS; r++) begin : g_remote
		logic [tlio_pkg::SEL_W-1:0] sel;
		assign sel = REMOTE_OUTPUT_ALLOCATION[r*tlio_pkg::SEL_W +: tlio_pkg::SEL_W];
		always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
			if (SYS_RST) begin
				REMOTE_OUT_N[r] <= tlio_pkg::LEVEL_INACTIVE;
			end else if (CLK_EN) begin
				REMOTE_OUT_N[r] <= eff_word[tlio_pkg::REMOTE_OUT_LSB + int'(sel)];
			end
		end
	end

endmodule : tlio_top

`default_nettype wire

// >>> dv/tlio_master.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Fieldbus master issuing object accesses
// ****************************************
module tlio_master (
	input  wire logic                       clk,
	input  wire logic                       ack,
	input  wire logic                       err,
	input  wire logic [31:0]                rdata,
	output var  tlio_pkg::tlio_obj_req_type req
);
	initial req = '0;

	task automatic xfer(input logic [15:0] i, input logic [7:0] s, input logic w,
		input logic [31:0] d, output logic [31:0] rd, output logic a, output logic e);
		@(negedge clk);
		req = '{i, s, w, !w, d};
		// Answer registered at the taking edge, settled by the next falling one
		@(negedge clk);
		rd = rdata;
		a = ack;
		e = err;
		// Released data flips so a stale word is never mistaken for fresh
		req = '{16'h0000, 8'h00, 1'b0, 1'b0, ~d};
	endtask : xfer
endmodule : tlio_master

`default_nettype wire

// >>> dv/tlio_chk.sv
`timescale 1ns/1ps
`default_nettype none

module tlio_chk #(
	parameter int TORQUE_W = 16
) (
	input  wire logic                       CLK_SYS,
	input  wire logic                       SYS_RST,
	input  wire logic                       CLK_EN,
	input  wire tlio_pkg::tlio_obj_req_type OBJ_REQ,
	input  wire logic [31:0]                OBJ_RDATA,
	input  wire logic                       OBJ_ACK,
	input  wire logic                       OBJ_ERR,
	input  wire logic signed [TORQUE_W-1:0] TORQUE_REF,
	input  wire logic signed [TORQUE_W-1:0] TORQUE_OUT,
	input  wire tlio_pkg::tlio_limit_type   TORQUE_LIMIT,
	input  wire logic [3:0]                 BUS_OUTPUT_ENABLE_A,
	input  wire logic [3:0]                 BUS_OUTPUT_ENABLE_B,
	input  wire logic [3:0]                 OUTPUT_POLARITY_SETTING_A,
	input  wire logic [3:0]                 OUTPUT_POLARITY_SETTING_B,
	input  wire logic [3:0]                 IO_CONNECTOR_OUT_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	function automatic int clampf(int r, int p, int n);
		return (r > p) ? p : ((r < -n) ? -n : r);
	endfunction : clampf

	AST_ACK_ON_REQ: assert property (CLK_EN && (OBJ_REQ.read || OBJ_REQ.write) |=> OBJ_ACK)
		else $error("no ack after access");
	AST_NO_ACK_IDLE: assert property (CLK_EN && !OBJ_REQ.read && !OBJ_REQ.write |=> !OBJ_ACK)
		else $error("ack without access");
	AST_RDATA_ZERO: assert property (CLK_EN && !OBJ_REQ.read |=> OBJ_RDATA == 32'h0000_0000)
		else $error("read data not zero");
	AST_RO_ERR: assert property (CLK_EN && OBJ_REQ.write && OBJ_REQ.index == 16'h60FD |=> OBJ_ERR)
		else $error("input word write accepted");
	AST_ERR_WITH_ACK: assert property (OBJ_ERR |-> OBJ_ACK)
		else $error("error without ack");
	AST_CLAMP: assert property (CLK_EN ##1 (CLK_EN && $stable(TORQUE_LIMIT)) |->
		int'(TORQUE_OUT) == clampf(int'($past(TORQUE_REF)), int'(TORQUE_LIMIT.pos),
		int'(TORQUE_LIMIT.neg))) else $error("torque not clamped");
	AST_GP_IDLE: assert property (((BUS_OUTPUT_ENABLE_A | BUS_OUTPUT_ENABLE_B) == 4'h0 &&
		(OUTPUT_POLARITY_SETTING_A ^ OUTPUT_POLARITY_SETTING_B) == 4'h0) [*2]
		|-> IO_CONNECTOR_OUT_N == 4'hF) else $error("bus output without enable");
	AST_IN_RESV: assert property (CLK_EN && OBJ_REQ.read && OBJ_REQ.index == 16'h60FD |=>
		OBJ_RDATA[15:3] == 13'h0000 && OBJ_RDATA[31:21] == 11'h000)
		else $error("reserved input bits set");
endmodule : tlio_chk

bind tlio_top tlio_chk #(.TORQUE_W(TORQUE_W)) u_tlio_chk (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .OBJ_REQ(OBJ_REQ),
	.OBJ_RDATA(OBJ_RDATA), .OBJ_ACK(OBJ_ACK), .OBJ_ERR(OBJ_ERR), .TORQUE_REF(TORQUE_REF),
	.TORQUE_OUT(TORQUE_OUT), .TORQUE_LIMIT(TORQUE_LIMIT),
	.BUS_OUTPUT_ENABLE_A(BUS_OUTPUT_ENABLE_A), .BUS_OUTPUT_ENABLE_B(BUS_OUTPUT_ENABLE_B),
	.OUTPUT_POLARITY_SETTING_A(OUTPUT_POLARITY_SETTING_A),
	.OUTPUT_POLARITY_SETTING_B(OUTPUT_POLARITY_SETTING_B),
	.IO_CONNECTOR_OUT_N(IO_CONNECTOR_OUT_N));

`default_nettype wire

// >>> dv/tlio_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tlio_top_bench;
	logic                       clk_sys;
	logic                       sys_rst;
	logic                       ce;
	tlio_pkg::tlio_obj_req_type req;
	logic [31:0]                rdata;
	logic                       ack;
	logic                       err;
	logic signed [15:0]         t_ref;
	logic signed [15:0]         t_out;
	tlio_pkg::tlio_limit_type   lim;
	logic [2:0]                 sw;
	logic [4:0]                 conn_n;
	logic [4:0]                 al_a;
	logic [4:0]                 al_b;
	logic [4:0]                 conn_int_n;
	logic [7:0]                 gp_rt;
	logic [7:0]                 rm_rt;
	logic [3:0]                 en_a;
	logic [3:0]                 en_b;
	logic [3:0]                 pol_a;
	logic [3:0]                 pol_b;
	logic [3:0]                 gp_n;
	logic [3:0]                 rm_n;
	int                         num_errors = 0;
	int                         n_checks = 0;

	tlio_top u_tlio_top (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(ce), .OBJ_REQ(req),
		.OBJ_RDATA(rdata), .OBJ_ACK(ack), .OBJ_ERR(err), .TORQUE_REF(t_ref), .TORQUE_OUT(t_out),
		.TORQUE_LIMIT(lim), .NEG_OVERTRAVEL_SWITCH(sw[0]), .POSITIVE_OVERTRAVEL_SWITCH(sw[1]),
		.HOME_SWITCH(sw[2]), .IO_CONNECTOR_IN_N(conn_n), .INPUT_ALLOCATION_SETTING_A(al_a),
		.INPUT_ALLOCATION_SETTING_B(al_b), .CONN_INTERNAL_N(conn_int_n), .GP_OUTPUT_ROUTE(gp_rt),
		.BUS_OUTPUT_ENABLE_A(en_a), .BUS_OUTPUT_ENABLE_B(en_b), .OUTPUT_POLARITY_SETTING_A(pol_a),
		.OUTPUT_POLARITY_SETTING_B(pol_b), .IO_CONNECTOR_OUT_N(gp_n),
		.REMOTE_OUTPUT_ALLOCATION(rm_rt), .REMOTE_OUT_N(rm_n));
	tlio_master u_tlio_master (.clk(clk_sys), .ack(ack), .err(err), .rdata(rdata), .req(req));

	task automatic conclude;
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	// For a read the data argument is the expected word
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic ee);
		logic [31:0] rv;
		logic        av;
		logic        ev;
		u_tlio_master.xfer(i, s, w, d, rv, av, ev);
		chk({30'h0, av, ev}, {30'h0, 1'b1, ee});
		if (!w) chk(rv, d);
	endtask : acc

	task automatic trq(input logic [15:0] rf, input logic [15:0] ex);
		t_ref = rf;
		tick(1);
		chk({16'h0000, t_out}, {16'h0000, ex});
	endtask : trq

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		{t_ref, sw, conn_n, al_a, al_b} = {16'h0000, 3'h0, 5'h1F, 5'h00, 5'h00};
		{gp_rt, rm_rt, en_a, en_b, pol_a, pol_b} = {8'hE4, 8'hE4, 16'h0000};
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		acc(0, 16'h6072, 8'h00, 32'h0000_0BB8, 0);
		acc(0, 16'h60FE, 8'h00, 32'h0000_0002, 0);
		acc(0, 16'h60FE, 8'h01, 32'h0000_0000, 0);
		acc(0, 16'h60FE, 8'h02, 32'h0000_0000, 0);
		chk(lim, {16'h0BB8, 16'h0BB8});
		chk({24'h0, gp_n, rm_n}, 32'h0000_00FF);
		acc(1, 16'h60FD, 8'h00, 32'hFFFF_FFFF, 1);
		acc(1, 16'h60FE, 8'h00, 32'h0000_0005, 1);
		acc(1, 16'h1234, 8'h00, 32'h0000_0000, 1);
		acc(1, 16'h60E0, 8'h00, 32'h0000_03E8, 0);
		acc(1, 16'h60E1, 8'h00, 32'h0000_1388, 0);
		tick(1);
		chk(lim, {16'h03E8, 16'h0BB8});
		trq(16'h07D0, 16'h03E8);
		trq(16'hF060, 16'hF448);
		trq(16'hFF9C, 16'hFF9C);
		acc(1, 16'h6072, 8'h00, 32'h0000_01F4, 0);
		tick(1);
		chk(lim, {16'h01F4, 16'h01F4});
		trq(16'hF060, 16'hFE0C);
		trq(16'h02BC, 16'h01F4);
		for (int k = 0; k < 2; k++) begin
			{sw, conn_n} = k ? 8'h49 : 8'hB6;
			tick(6);
			acc(0, 16'h60FD, 8'h00, {11'h000, conn_n, 13'h0000, sw}, 0);
			chk({27'h0, conn_int_n}, {27'h0, conn_n});
		end
		{al_a, al_b} = {5'h01, 5'h10};
		tick(6);
		chk({27'h0, conn_int_n}, {27'h0, conn_n | 5'h11});
		acc(0, 16'h60FD, 8'h00, {11'h000, conn_n, 13'h0000, sw}, 0);
		acc(1, 16'h60FE, 8'h01, 32'hFFFF_FFFF, 0);
		acc(0, 16'h60FE, 8'h01, 32'h0F0F_0000, 0);
		acc(1, 16'h60FE, 8'h01, 32'h0905_0000, 0);
		tick(1);
		chk({24'h0, gp_n, rm_n}, 32'h0000_00FF);
		acc(1, 16'h60FE, 8'h02, 32'hFFFF_FFFF, 0);
		tick(1);
		chk({24'h0, gp_n, rm_n}, 32'h0000_00F9);
		en_a = 4'hF;
		tick(1);
		chk({28'h0, gp_n}, 32'h0000_0005);
		{pol_a, pol_b} = {4'h3, 4'h1};
		tick(1);
		chk({28'h0, gp_n}, 32'h0000_0007);
		{en_a, en_b, pol_a, pol_b, gp_rt} = {4'h0, 4'hF, 8'h00, 8'h1B};
		tick(1);
		chk({28'h0, gp_n}, 32'h0000_000A);
		acc(1, 16'h60FE, 8'h02, 32'h0300_0000, 0);
		tick(1);
		chk({24'h0, gp_n, rm_n}, 32'h0000_00FD);
		rm_rt = 8'h1B;
		tick(1);
		chk({28'h0, rm_n}, 32'h0000_000B);
		// Clock enable low must freeze the clamp output
		ce = 1'b0;
		t_ref = 16'h0064;
		tick(2);
		chk({16'h0000, t_out}, 32'h0000_01F4);
		ce = 1'b1;
		tick(1);
		chk({16'h0000, t_out}, 32'h0000_0064);
		conclude();
	end
endmodule : tlio_top_bench

`default_nettype wire
